// ---- design/mcst_consts.vh ----
// timing, address and field constants for the module control and status block
`ifndef MCST_CONSTS_VH
`define MCST_CONSTS_VH
`define MCST_CLK_KHZ 50000
`define MCST_CLK_MHZ 50
`define MCST_T_RESET_US 10
`define MCST_T_INIT_MS 300
`define MCST_T_DATA_MS 1000
`define MCST_T_WR4_MS 40
`define MCST_T_WR8_MS 80
`define MCST_INIT_CYC 26'hE4E1C0
`define MCST_DATA_CYC 26'h2FAF080
`define MCST_WR4_CYC 22'h1E8480
`define MCST_WR8_CYC 22'h3D0900
`define MCST_RESET_CYC 10'h1F4
`define MCST_SOFT_OFF_RST 1'h0
`define MCST_SYNC_IDLE 5'h18
`define MCST_ID_ADDR 7'h50
`define MCST_DIAG_ADDR 7'h51
`define MCST_CSB_OFS 8'h6E
`define MCST_CSB_RESET 8'h00
`define MCST_BIT_PIN_OFF 7
`define MCST_BIT_SOFT_OFF 6
`define MCST_BIT_FAULT 2
`define MCST_BIT_LOS 1
`define MCST_BIT_READY 0
`define MCST_WR_SPLIT 4'h4
`endif

// ---- design/mcst_twi.v ----
// two-wire management bus slave: byte framing, address match, acknowledge
`timescale 1ns/1ns
`include "mcst_consts.vh"
module mcst_twi (
  // clock and reset
  input wire i_mclk,
  input wire i_rst_n,
  // synchronised bus pins
  input wire i_scl,
  input wire i_sda,
  // control from the register side
  input wire i_ready,
  input wire i_busy,
  input wire [7:0] i_rd_data,
  // bus drive and register access
  output reg o_sda_oe,
  output reg o_dev_diag,
  output reg [7:0] o_ptr,
  output reg o_wr_stb,
  output reg [7:0] o_wr_data,
  output reg o_stop
);
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_ADDR = 7'h02;
  localparam [6:0] S_ACKA = 7'h04;
  localparam [6:0] S_WR = 7'h08;
  localparam [6:0] S_ACKW = 7'h10;
  localparam [6:0] S_RD = 7'h20;
  localparam [6:0] S_ACKR = 7'h40;

  function addr_hit;
    input [6:0] a;
    begin
      addr_hit = (a == `MCST_ID_ADDR) || (a == `MCST_DIAG_ADDR);
    end
  endfunction

  reg [6:0] st_q;
  reg scl_d_q;
  reg sda_d_q;
  reg [7:0] sh_q;
  reg [7:0] tx_q;
  reg [3:0] cnt_q;
  reg rw_q;
  reg phase_q;
  reg nack_q;
  wire rise = i_scl & ~scl_d_q;
  wire fall = ~i_scl & scl_d_q;
  wire start = scl_d_q & i_scl & sda_d_q & ~i_sda;
  wire stop = scl_d_q & i_scl & ~sda_d_q & i_sda;

  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= S_IDLE;
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      cnt_q <= 4'h0;
      rw_q <= 1'b0;
      phase_q <= 1'b0;
      nack_q <= 1'b1;
      o_sda_oe <= 1'b0;
      o_dev_diag <= 1'b0;
      o_ptr <= 8'h00;
      o_wr_stb <= 1'b0;
      o_wr_data <= 8'h00;
      o_stop <= 1'b0;
    end else begin
      scl_d_q <= i_scl;
      sda_d_q <= i_sda;
      o_wr_stb <= 1'b0;
      o_stop <= stop;
      if (start) begin
        st_q <= S_ADDR;
        cnt_q <= 4'h0;
        o_sda_oe <= 1'b0;
      end else if (stop) begin
        st_q <= S_IDLE;
        o_sda_oe <= 1'b0;
      end else begin
        if (rise && (st_q == S_ADDR || st_q == S_WR || st_q == S_RD)) begin
          sh_q <= {sh_q[6:0], i_sda};
          cnt_q <= cnt_q + 4'h1;
        end
        if (rise && st_q == S_ACKR) begin
          nack_q <= i_sda;
        end
        if (fall) begin
          case (st_q)
            S_IDLE: begin
              o_sda_oe <= 1'b0;
            end
            S_ADDR: begin
              if (cnt_q == 4'h8) begin
                // no answer before ready or during a write cycle
                if (addr_hit(sh_q[7:1]) && i_ready && !i_busy) begin
                  o_dev_diag <= sh_q[1];
                  rw_q <= sh_q[0];
                  o_sda_oe <= 1'b1;
                  st_q <= S_ACKA;
                end else begin
                  st_q <= S_IDLE;
                end
              end
            end
            S_ACKA: begin
              cnt_q <= 4'h0;
              if (rw_q) begin
                tx_q <= i_rd_data;
                o_sda_oe <= ~i_rd_data[7];
                st_q <= S_RD;
              end else begin
                o_sda_oe <= 1'b0;
                phase_q <= 1'b1;
                st_q <= S_WR;
              end
            end
            S_WR: begin
              if (cnt_q == 4'h8) begin
                o_sda_oe <= 1'b1;
                st_q <= S_ACKW;
                if (phase_q) begin
                  o_ptr <= sh_q;
                end else begin
                  o_wr_stb <= 1'b1;
                  o_wr_data <= sh_q;
                end
              end
            end
            S_ACKW: begin
              o_sda_oe <= 1'b0;
              cnt_q <= 4'h0;
              st_q <= S_WR;
              phase_q <= 1'b0;
              if (!phase_q) begin
                o_ptr <= o_ptr + 8'h01;
              end
            end
            S_RD: begin
              if (cnt_q == 4'h8) begin
                o_sda_oe <= 1'b0;
                o_ptr <= o_ptr + 8'h01;
                st_q <= S_ACKR;
              end else begin
                o_sda_oe <= ~tx_q[6];
                tx_q <= {tx_q[6:0], 1'b0};
              end
            end
            S_ACKR: begin
              cnt_q <= 4'h0;
              if (!nack_q) begin
                tx_q <= i_rd_data;
                o_sda_oe <= ~i_rd_data[7];
                st_q <= S_RD;
              end else begin
                st_q <= S_IDLE;
              end
            end
            default: begin
              st_q <= S_IDLE;
              o_sda_oe <= 1'b0;
            end
          endcase
        end
      end
    end
  end
endmodule // mcst_twi

// ---- design/mcst_top.v ----
// low-speed control and status of a pluggable optical module
`timescale 1ns/1ns
`include "mcst_consts.vh"
// Behaviour
// - pin rising edge turns laser off fast
// - pin falling edge restores laser quickly
// - init clears fault, restores output, bus
// - fault output asserts well inside 100 us
// - lost signal raises los output quickly
// - returning signal drops los output quickly
// - soft off bit disables laser after stop
// - clearing soft off restores laser output
// - fault status bit follows fault latch
// - los status bit set on signal loss
// - los status bit cleared on return
// - data ready bit set after 1000 ms
// - bus answers both addresses after 300 ms
// - write cycle 40 or 80 ms by size
module mcst_top #(
  parameter [25:0] P_INIT_CYC = `MCST_INIT_CYC,
  parameter [25:0] P_DATA_CYC = `MCST_DATA_CYC,
  parameter [21:0] P_WR4_CYC = `MCST_WR4_CYC,
  parameter [21:0] P_WR8_CYC = `MCST_WR8_CYC
) (
  // clock and reset
  input wire i_mclk,
  input wire i_rst_n,
  // module pins
  input wire i_tx_off,
  input wire i_fault_det,
  input wire i_sig_det,
  // management bus
  input wire i_scl,
  input wire i_sda,
  output wire o_sda,
  output wire o_sda_oe,
  // status and laser control
  output reg o_laser_en,
  output reg o_tx_fault,
  output reg o_rx_los,
  output reg o_data_ready
);
  localparam [9:0] L_RESET_CYC = `MCST_RESET_CYC;
  // bus pins idle high, so no false edge after reset
  localparam [4:0] L_SYNC_IDLE = `MCST_SYNC_IDLE;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire [4:0] pin_raw = {i_scl, i_sda, i_tx_off, i_fault_det, i_sig_det};
  reg [4:0] sync1_q;
  reg [4:0] sync2_q;
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : g_sync
      always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          sync1_q[g] <= L_SYNC_IDLE[g];
          sync2_q[g] <= L_SYNC_IDLE[g];
        end else begin
          sync1_q[g] <= pin_raw[g];
          sync2_q[g] <= sync1_q[g];
        end
      end
    end
  endgenerate
  wire scl_s = sync2_q[4];
  wire sda_s = sync2_q[3];
  wire off_s = sync2_q[2];
  wire fault_s = sync2_q[1];
  wire sig_s = sync2_q[0];

  // ----------------------------------------
  // power-on timing
  // ----------------------------------------
  reg [25:0] por_cnt_q;
  reg twi_ready_q;
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      por_cnt_q <= 26'h0000000;
      twi_ready_q <= 1'b0;
      o_data_ready <= 1'b0;
    end else begin
      if (por_cnt_q < P_DATA_CYC) begin
        por_cnt_q <= por_cnt_q + 26'h0000001;
      end
      twi_ready_q <= (por_cnt_q >= P_INIT_CYC);
      o_data_ready <= (por_cnt_q >= P_DATA_CYC);
    end
  end

  // ----------------------------------------
  // disable pin and fault latch
  // ----------------------------------------
  reg off_d_q;
  reg [9:0] off_cnt_q;
  reg fault_q;
  wire off_fall = off_d_q & ~off_s;
  wire fault_clr = off_fall & (off_cnt_q >= L_RESET_CYC);
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      off_d_q <= 1'b0;
      off_cnt_q <= 10'h000;
      fault_q <= 1'b0;
    end else begin
      off_d_q <= off_s;
      if (!off_s) begin
        off_cnt_q <= 10'h000;
      end else if (off_cnt_q < L_RESET_CYC) begin
        off_cnt_q <= off_cnt_q + 10'h001;
      end
      // a new fault wins over the clear
      if (fault_s) begin
        fault_q <= 1'b1;
      end else if (fault_clr) begin
        fault_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // control/status byte and write cycle
  // ----------------------------------------
  wire dev_diag;
  wire [7:0] ptr;
  wire wr_stb;
  wire [7:0] wr_data;
  wire bus_stop;
  reg soft_off_q;
  reg pend_q;
  reg pend_vld_q;
  reg [3:0] wr_bytes_q;
  reg [21:0] busy_cnt_q;
  wire busy = (busy_cnt_q != 22'h000000);
  wire csb_hit = dev_diag & (ptr == `MCST_CSB_OFS);
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      soft_off_q <= `MCST_SOFT_OFF_RST;
      pend_q <= 1'b0;
      pend_vld_q <= 1'b0;
      wr_bytes_q <= 4'h0;
      busy_cnt_q <= 22'h000000;
    end else begin
      if (busy) begin
        busy_cnt_q <= busy_cnt_q - 22'h000001;
      end
      if (wr_stb) begin
        if (wr_bytes_q != 4'hF) begin
          wr_bytes_q <= wr_bytes_q + 4'h1;
        end
        if (csb_hit) begin
          pend_q <= wr_data[`MCST_BIT_SOFT_OFF];
          pend_vld_q <= 1'b1;
        end
      end
      if (bus_stop) begin
        wr_bytes_q <= 4'h0;
        pend_vld_q <= 1'b0;
        if (wr_bytes_q != 4'h0) begin
          busy_cnt_q <= (wr_bytes_q <= `MCST_WR_SPLIT) ? P_WR4_CYC : P_WR8_CYC;
        end
        if (pend_vld_q) begin
          soft_off_q <= pend_q;
        end
      end
    end
  end

  reg [7:0] csb;
  always @* begin
    csb = 8'h00;
    csb[`MCST_BIT_PIN_OFF] = off_s;
    csb[`MCST_BIT_SOFT_OFF] = soft_off_q;
    csb[`MCST_BIT_FAULT] = fault_q;
    csb[`MCST_BIT_LOS] = ~sig_s;
    csb[`MCST_BIT_READY] = o_data_ready;
  end
  wire [7:0] rd_data = csb_hit ? csb : 8'h00;

  // ----------------------------------------
  // output pins
  // ----------------------------------------
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_laser_en <= 1'b0;
      o_tx_fault <= 1'b0;
      o_rx_los <= 1'b1;
    end else begin
      o_laser_en <= ~(off_s | soft_off_q | fault_q);
      o_tx_fault <= fault_q;
      o_rx_los <= ~sig_s;
    end
  end
  // open drain: only the enable moves
  assign o_sda = 1'b0;

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  mcst_twi u_twi (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_scl(scl_s),
    .i_sda(sda_s),
    .i_ready(twi_ready_q),
    .i_busy(busy),
    .i_rd_data(rd_data),
    .o_sda_oe(o_sda_oe),
    .o_dev_diag(dev_diag),
    .o_ptr(ptr),
    .o_wr_stb(wr_stb),
    .o_wr_data(wr_data),
    .o_stop(bus_stop)
  );
endmodule // mcst_top

// ---- sim/mcst_top_props.sv ----
// assertion checker for the control and status block
`timescale 1ns/1ns
module mcst_top_props #(
  parameter [25:0] P_INIT_CYC = 26'h12C,
  parameter [25:0] P_DATA_CYC = 26'h258,
  parameter [21:0] P_WR4_CYC = 22'h7D0,
  parameter [21:0] P_WR8_CYC = 22'hFA0
) (
  // clock and reset
  input wire i_mclk,
  input wire i_rst_n,
  // pins and bus
  input wire i_tx_off,
  input wire i_fault_det,
  input wire i_sig_det,
  input wire i_scl,
  input wire i_sda,
  input wire o_sda,
  input wire o_sda_oe,
  input wire o_laser_en,
  input wire o_tx_fault,
  input wire o_rx_los,
  input wire o_data_ready
);
  // ----------
  // power-on count
  // ----------
  reg [25:0] por_q;
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) por_q <= 26'h0000000;
    else if (por_q != 26'h3FFFFFF) por_q <= por_q + 26'h0000001;
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  sequence s_laser_off; ##[1:4] !o_laser_en; endsequence
  sequence s_los_set; ##[1:4] o_rx_los; endsequence
  sequence s_los_clr; ##[1:4] !o_rx_los; endsequence
  property p_pin_off; $rose(i_tx_off) |-> s_laser_off; endproperty
  property p_pin_hold; i_tx_off [*5] |-> !o_laser_en; endproperty
  property p_los_set; $fell(i_sig_det) |-> s_los_set; endproperty
  property p_los_clr; $rose(i_sig_det) |-> s_los_clr; endproperty
  property p_fault; $rose(i_fault_det) |-> ##[1:5] o_tx_fault; endproperty
  property p_init_nack; por_q < P_INIT_CYC |-> !o_sda_oe; endproperty
  property p_ready_late; por_q == P_DATA_CYC + 26'h4 |-> o_data_ready; endproperty
  property p_ready_early; por_q < P_DATA_CYC - 26'h4 |-> !o_data_ready; endproperty
  a_pin_off: assert property (p_pin_off) else $error("laser on after pin rise");
  a_pin_hold: assert property (p_pin_hold) else $error("laser on with pin high");
  a_los_set: assert property (p_los_set) else $error("los late on loss");
  a_los_clr: assert property (p_los_clr) else $error("los late on return");
  a_fault: assert property (p_fault) else $error("fault output late");
  a_init_nack: assert property (p_init_nack) else $error("ack before init");
  a_ready_late: assert property (p_ready_late) else $error("data ready late");
  a_ready_early: assert property (p_ready_early) else $error("data ready early");
endmodule // mcst_top_props
bind mcst_top mcst_top_props #(.P_INIT_CYC(P_INIT_CYC), .P_DATA_CYC(P_DATA_CYC),
  .P_WR4_CYC(P_WR4_CYC), .P_WR8_CYC(P_WR8_CYC)) i_props (.i_mclk(i_mclk),
  .i_rst_n(i_rst_n), .i_tx_off(i_tx_off), .i_fault_det(i_fault_det), .i_sig_det(i_sig_det),
  .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .o_laser_en(o_laser_en),
  .o_tx_fault(o_tx_fault), .o_rx_los(o_rx_los), .o_data_ready(o_data_ready));

// ---- sim/mcst_host.sv ----
// host controller model: two-wire bus master
`timescale 1ns/1ns
`include "mcst_consts.vh"
module mcst_host (
  // device pull
  input wire i_sda_oe,
  input wire i_sda_dv,
  // bus lines
  output wire o_scl,
  output wire o_sda
);
  logic scl_q = 1'b1;
  logic pull_q = 1'b0;
  assign o_scl = scl_q;
  // pull-up: line high unless someone pulls
  assign o_sda = !(pull_q || (i_sda_oe && !i_sda_dv));
  task automatic bit_io(input logic b, output logic r);
    pull_q = !b; #40 scl_q = 1'b1; #40 r = o_sda; #40 scl_q = 1'b0; #40;
  endtask
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic start;
    pull_q = 1'b0; #40 scl_q = 1'b1; #40 pull_q = 1'b1; #40 scl_q = 1'b0; #40;
  endtask
  task automatic stop;
    pull_q = 1'b1; #40 scl_q = 1'b1; #40 pull_q = 1'b0;
    #20000;
  endtask
  task automatic probe(input logic [6:0] a, output logic ack);
    logic [7:0] q;
    start; xfer({a, 1'b0}, q, ack); stop;
  endtask
  task automatic wr(input logic [7:0] d, input int n, output logic ack);
    logic [7:0] q;
    logic a;
    start; xfer({`MCST_DIAG_ADDR, 1'b0}, q, ack); xfer(`MCST_CSB_OFS, q, a);
    repeat (n) xfer(d, q, a);
    stop;
  endtask
  task automatic rd(output logic [7:0] q);
    logic a;
    start; xfer({`MCST_DIAG_ADDR, 1'b0}, q, a); xfer(`MCST_CSB_OFS, q, a);
    start; xfer({`MCST_DIAG_ADDR, 1'b1}, q, a); xfer(8'hFF, q, a); stop;
  endtask
endmodule // mcst_host

// ---- sim/mcst_top_bench.sv ----
// self-checking bench for the control and status block
`timescale 1ns/1ns
`include "mcst_consts.vh"
module mcst_top_bench;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic tx_off = 1'b0;
  logic flt = 1'b0;
  logic sig = 1'b1;
  wire scl, sda, sda_oe, sda_dv, laser, fault_o, los, rdy;
  int err_count = 0;
  int comparisons = 0;
  always #10 i_mclk = ~i_mclk;
  mcst_top #(.P_INIT_CYC(26'h12C), .P_DATA_CYC(26'h258), .P_WR4_CYC(22'h7D0),
    .P_WR8_CYC(22'hFA0)) i_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_tx_off(tx_off),
    .i_fault_det(flt), .i_sig_det(sig), .i_scl(scl), .i_sda(sda), .o_sda(sda_dv),
    .o_sda_oe(sda_oe), .o_laser_en(laser), .o_tx_fault(fault_o), .o_rx_los(los),
    .o_data_ready(rdy));
  mcst_host i_host (.i_sda_oe(sda_oe), .i_sda_dv(sda_dv), .o_scl(scl), .o_sda(sda));
  // ----------
  // shared tasks
  // ----------
  task automatic cyc(input int n); repeat (n) @(negedge i_mclk); endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out;
    if (err_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // nacked probes until the write cycle ends, ~1084 cycles apart
  task automatic polls(output logic [7:0] n);
    logic a;
    n = 8'h00;
    a = 1'b0;
    while (!a && n < 8'h08) begin
      i_host.probe(`MCST_DIAG_ADDR, a);
      if (!a) n++;
    end
  endtask
  // ----------
  // scenarios
  // ----------
  task automatic t_bus_ready;
    logic a;
    check("ready early", 1'b0, rdy);
    check("fault at init", 1'b0, fault_o);
    i_host.probe(`MCST_DIAG_ADDR, a); check("early ack", 1'b0, a);
    i_host.probe(`MCST_ID_ADDR, a); check("id ack", 1'b1, a);
    i_host.probe(`MCST_DIAG_ADDR, a); check("diag ack", 1'b1, a);
  endtask
  task automatic t_pin;
    check("laser init", 1'b1, laser);
    check("ready pin", 1'b1, rdy);
    tx_off = 1'b1; cyc(6); check("pin off", 1'b0, laser);
    tx_off = 1'b0; cyc(6); check("pin on", 1'b1, laser);
  endtask
  task automatic t_fault;
    logic [7:0] b;
    flt = 1'b1; cyc(6); check("fault pin", 1'b1, fault_o);
    flt = 1'b0;
    i_host.rd(b); check("status fault", 8'h05, b);
    tx_off = 1'b1; cyc(100); tx_off = 1'b0; cyc(6);
    check("short clear", 1'b1, fault_o);
    tx_off = 1'b1; cyc(`MCST_T_RESET_US * `MCST_CLK_MHZ + 100); tx_off = 1'b0; cyc(6);
    check("fault clear", 1'b0, fault_o);
    check("laser back", 1'b1, laser);
  endtask
  task automatic t_los;
    logic [7:0] b;
    sig = 1'b0; cyc(6); check("los pin", 1'b1, los);
    i_host.rd(b); check("status los", 8'h03, b);
    sig = 1'b1; cyc(6); check("los clear", 1'b0, los);
    i_host.rd(b); check("status ok", 8'h01, b);
  endtask
  task automatic t_soft;
    logic a;
    logic [7:0] b;
    i_host.wr(8'h40, 1, a); check("soft off", 1'b0, laser);
    polls(b); check("short write busy", 8'h01, b);
    i_host.rd(b); check("status soft", 8'h41, b);
    tx_off = 1'b1;
    i_host.wr(8'h00, 5, a); check("pin keeps off", 1'b0, laser);
    polls(b); check("long write busy", 8'h03, b);
    i_host.rd(b); check("status pin", 8'h81, b);
    tx_off = 1'b0; cyc(6); check("soft on", 1'b1, laser);
  endtask
  initial begin
    cyc(20);
    i_rst_n = 1'b1;
    t_bus_ready;
    t_pin;
    t_fault;
    t_los;
    t_soft;
    close_out;
  end
  initial begin
    cyc(40000);
    err_count++;
    close_out;
  end
endmodule // mcst_top_bench
